// file: hdl/brf_if.sv
// Connection between the block memory and the fabric logic that drives it.
interface brf_if #(
  parameter int DATA_W = brf_pkg::BRF_DATA_W,
  parameter int ADDR_W = brf_pkg::BRF_ADDR_W
);
  // Driven by the fabric logic.
  brf_pkg::brf_mode_e mode;
  logic gsr_enable;
  logic sync_reset_sel;
  logic global_set_reset;
  logic fifo_reset;
  logic read_pointer_clear;
  logic write_port_clock;
  logic read_port_clock;
  logic wr_ce;
  logic rd_ce;
  logic wr_strobe;
  logic drain_strobe;
  logic [1:0] write_port_select;
  logic [1:0] read_port_select;
  logic full_input;
  logic empty_input;
  logic output_register_enable;
  logic output_read_enable;
  logic [DATA_W/8-1:0] byte_lane_enable;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  // Driven by the memory.
  logic [DATA_W-1:0] rd_data;
  logic read_ack;
  logic full_flag;
  logic almost_full_flag;
  logic empty_flag;
  logic almost_empty_flag;

  modport dev (
    input mode, gsr_enable, sync_reset_sel, global_set_reset, fifo_reset,
    input read_pointer_clear, write_port_clock, read_port_clock, wr_ce, rd_ce,
    input wr_strobe, drain_strobe, write_port_select, read_port_select,
    input full_input, empty_input, output_register_enable, output_read_enable,
    input byte_lane_enable, addr, wr_data,
    output rd_data, read_ack, full_flag, almost_full_flag, empty_flag,
    output almost_empty_flag
  );

  modport usr (
    output mode, gsr_enable, sync_reset_sel, global_set_reset, fifo_reset,
    output read_pointer_clear, write_port_clock, read_port_clock, wr_ce, rd_ce,
    output wr_strobe, drain_strobe, write_port_select, read_port_select,
    output full_input, empty_input, output_register_enable, output_read_enable,
    output byte_lane_enable, addr, wr_data,
    input rd_data, read_ack, full_flag, almost_full_flag, empty_flag,
    input almost_empty_flag
  );
endinterface : brf_if

// file: hdl/brf_mem_dev.sv
// Embedded block memory usable as RAM, ROM or FIFO with hard pointers and flags.

module brf_mem_dev #(
  parameter int DATA_W = brf_pkg::BRF_DATA_W,
  parameter int ADDR_W = brf_pkg::BRF_ADDR_W,
  parameter int AF_LEVEL = brf_pkg::BRF_AF_LEVEL,
  parameter int AE_LEVEL = brf_pkg::BRF_AE_LEVEL
) (
  input wire logic CLOCK_IN,
  input wire logic RESET_N_IN,
  input wire logic CLK_EN_IN,
  brf_if.dev MEM_IF
);
  import brf_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;
  localparam int NBYTE = DATA_W / 8;
  localparam logic [ADDR_W:0] FILL_FULL = DEPTH[ADDR_W:0];
  localparam logic [ADDR_W:0] FILL_AF = AF_LEVEL[ADDR_W:0];
  localparam logic [ADDR_W:0] FILL_AE = AE_LEVEL[ADDR_W:0];
  localparam logic [ADDR_W:0] PTR_ONE = {{ADDR_W{1'b0}}, 1'b1};

  // Storage is not reset; only pointers, flags, output stages and port clock history are.
  logic [DATA_W-1:0] mem [DEPTH];

  logic [ADDR_W:0] wr_ptr_reg;
  logic [ADDR_W:0] wr_ptr_next;
  logic [ADDR_W:0] rd_ptr_reg;
  logic [ADDR_W:0] rd_ptr_next;
  logic wr_tick_d_reg;
  logic rd_tick_d_reg;
  logic [DATA_W-1:0] rd_q_reg;
  logic [DATA_W-1:0] rd_data_reg;
  logic read_ack_reg;
  logic full_flag_reg;
  logic almost_full_flag_reg;
  logic empty_flag_reg;
  logic almost_empty_flag_reg;

  // ------------------------------------------------------------------
  // Mode and reset decoding
  // ------------------------------------------------------------------
  // The global set/reset cannot be masked in FIFO mode, so a FIFO always
  // comes up empty; in RAM and ROM it may be turned off to keep contents.
  wire fifo_mode = (MEM_IF.mode == BRF_MODE_FIFO);
  wire rom_mode = (MEM_IF.mode == BRF_MODE_ROM);
  wire gsr_active = MEM_IF.global_set_reset & (MEM_IF.gsr_enable | fifo_mode);
  wire rst_async = MEM_IF.fifo_reset & (fifo_mode | ~MEM_IF.sync_reset_sel);
  wire rst_sync = MEM_IF.fifo_reset & ~fifo_mode & MEM_IF.sync_reset_sel;
  wire core_rst_n = RESET_N_IN & ~gsr_active & ~rst_async;
  wire rd_rst_n = core_rst_n & ~(fifo_mode & MEM_IF.read_pointer_clear);

  // ------------------------------------------------------------------
  // Port clocks and selects
  // ------------------------------------------------------------------
  // Each port only acts on a rising edge of its own port clock, seen as a
  // change from low to high between two edges of the system clock.
  wire wr_edge = MEM_IF.write_port_clock & ~wr_tick_d_reg;
  wire rd_edge = MEM_IF.read_port_clock & ~rd_tick_d_reg;
  wire [2:0] wr_sel_bits = {MEM_IF.full_input, MEM_IF.write_port_select};
  wire [2:0] rd_sel_bits = {MEM_IF.empty_input, MEM_IF.read_port_select};
  wire wr_sel = (wr_sel_bits == BRF_WR_SEL_MATCH);
  wire rd_sel = (rd_sel_bits == BRF_RD_SEL_MATCH);

  // ------------------------------------------------------------------
  // Fill level and flag decoding
  // ------------------------------------------------------------------
  wire [ADDR_W:0] fill_now = wr_ptr_reg - rd_ptr_reg;
  wire full_now = (fill_now == FILL_FULL);
  wire empty_now = (fill_now == {(ADDR_W + 1){1'b0}});

  // The hard flags also guard the pointers, so a careless driver can
  // never overrun or underrun the storage.
  wire wr_go = CLK_EN_IN & wr_edge & MEM_IF.wr_ce & wr_sel & MEM_IF.wr_strobe
    & ~rom_mode & ~(fifo_mode & full_now);
  wire fifo_rd_go = CLK_EN_IN & rd_edge & MEM_IF.rd_ce & rd_sel & MEM_IF.drain_strobe
    & fifo_mode & ~empty_now;
  wire ram_rd_go = CLK_EN_IN & rd_edge & MEM_IF.rd_ce & rd_sel & ~fifo_mode;
  wire rd_go = fifo_rd_go | ram_rd_go;

  wire [ADDR_W-1:0] wr_addr = fifo_mode ? wr_ptr_reg[ADDR_W-1:0] : MEM_IF.addr;
  wire [ADDR_W-1:0] rd_addr = fifo_mode ? rd_ptr_reg[ADDR_W-1:0] : MEM_IF.addr;
  wire out_load = CLK_EN_IN & MEM_IF.output_register_enable
    & (~fifo_mode | MEM_IF.output_read_enable);

  assign wr_ptr_next = (wr_go & fifo_mode) ? (wr_ptr_reg + PTR_ONE) : wr_ptr_reg;
  assign rd_ptr_next = fifo_rd_go ? (rd_ptr_reg + PTR_ONE) : rd_ptr_reg;

  wire [ADDR_W:0] fill_next = wr_ptr_next - rd_ptr_next;
  wire full_next = fifo_mode & (fill_next == FILL_FULL);
  wire almost_full_next = fifo_mode & (fill_next >= FILL_AF);
  wire empty_next = ~fifo_mode | (fill_next == {(ADDR_W + 1){1'b0}});
  wire almost_empty_next = ~fifo_mode | (fill_next <= FILL_AE);

  // ------------------------------------------------------------------
  // Port clock edge history
  // ------------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      wr_tick_d_reg <= 1'b0;
      rd_tick_d_reg <= 1'b0;
    end else if (CLK_EN_IN) begin
      wr_tick_d_reg <= MEM_IF.write_port_clock;
      rd_tick_d_reg <= MEM_IF.read_port_clock;
    end
  end

  // ------------------------------------------------------------------
  // Write pointer
  // ------------------------------------------------------------------
  // Both pointers drop at once on the asynchronous resets, with no clock.
  always_ff @(posedge CLOCK_IN or negedge core_rst_n) begin
    if (!core_rst_n) begin
      wr_ptr_reg <= '0;
    end else if (CLK_EN_IN) begin
      wr_ptr_reg <= wr_ptr_next;
    end
  end

  // ------------------------------------------------------------------
  // Read pointer
  // ------------------------------------------------------------------
  // The pointer clear leaves the write pointer alone, so the data already
  // written can be read again from the start.
  always_ff @(posedge CLOCK_IN or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      rd_ptr_reg <= '0;
    end else if (CLK_EN_IN) begin
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // ------------------------------------------------------------------
  // Storage write with byte lanes
  // ------------------------------------------------------------------
  always_ff @(posedge CLOCK_IN) begin
    for (int b = 0; b < NBYTE; b++) begin
      if (wr_go && MEM_IF.byte_lane_enable[b]) begin
        mem[wr_addr][b*8 +: 8] <= MEM_IF.wr_data[b*8 +: 8];
      end
    end
  end

  // ------------------------------------------------------------------
  // Read stage and output register
  // ------------------------------------------------------------------
  // The synchronous reset option only clears the output stages; it is
  // seen at a clock edge, so it needs no ordering against the enables.
  always_ff @(posedge CLOCK_IN or negedge core_rst_n) begin
    if (!core_rst_n) begin
      rd_q_reg <= '0;
      read_ack_reg <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (rst_sync) begin
        rd_q_reg <= '0;
        read_ack_reg <= 1'b0;
      end else begin
        read_ack_reg <= rd_go;
        if (rd_go) begin
          rd_q_reg <= mem[rd_addr];
        end
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge core_rst_n) begin
    if (!core_rst_n) begin
      rd_data_reg <= '0;
    end else if (rst_sync && CLK_EN_IN) begin
      rd_data_reg <= '0;
    end else if (out_load) begin
      rd_data_reg <= rd_q_reg;
    end
  end

  // ------------------------------------------------------------------
  // Flags
  // ------------------------------------------------------------------
  // Flags follow the pointers one edge late after a pointer clear, since
  // they are registered from the settled fill level.
  always_ff @(posedge CLOCK_IN or negedge core_rst_n) begin
    if (!core_rst_n) begin
      full_flag_reg <= 1'b0;
      almost_full_flag_reg <= 1'b0;
      empty_flag_reg <= 1'b1;
      almost_empty_flag_reg <= 1'b1;
    end else if (CLK_EN_IN) begin
      full_flag_reg <= full_next;
      almost_full_flag_reg <= almost_full_next;
      empty_flag_reg <= empty_next;
      almost_empty_flag_reg <= almost_empty_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign MEM_IF.rd_data = rd_data_reg;
  assign MEM_IF.read_ack = read_ack_reg;
  assign MEM_IF.full_flag = full_flag_reg;
  assign MEM_IF.almost_full_flag = almost_full_flag_reg;
  assign MEM_IF.empty_flag = empty_flag_reg;
  assign MEM_IF.almost_empty_flag = almost_empty_flag_reg;

endmodule : brf_mem_dev

// file: hdl/brf_pkg.sv
// Shared constants and types for the block memory and its fabric driver.
package brf_pkg;

  // ------------------------------------------------------------------
  // Modes and sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    BRF_MODE_RAM = 2'b00,
    BRF_MODE_ROM = 2'b01,
    BRF_MODE_FIFO = 2'b10
  } brf_mode_e;

  typedef enum logic [2:0] {
    BRF_SEQ_BOOT = 3'b000,
    BRF_SEQ_IDLE = 3'b001,
    BRF_SEQ_QUIET = 3'b010,
    BRF_SEQ_HOLD = 3'b011,
    BRF_SEQ_SETTLE = 3'b100
  } brf_seq_e;

  // ------------------------------------------------------------------
  // Default sizes and flag levels
  // ------------------------------------------------------------------
  localparam int BRF_DATA_W = 16;
  localparam int BRF_ADDR_W = 4;
  localparam int BRF_AF_LEVEL = 12;
  localparam int BRF_AE_LEVEL = 2;

  // Select decode: both select bits high, full/empty input low.
  localparam logic [2:0] BRF_WR_SEL_MATCH = 3'b011;
  localparam logic [2:0] BRF_RD_SEL_MATCH = 3'b011;
  localparam logic [1:0] BRF_SEL_DRIVE = 2'b11;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int BRF_CLK_KHZ = 25000;
  localparam int BRF_MEM_FMAX_KHZ = 25000;
  localparam int BRF_STEADY_NS = 1000000 / BRF_MEM_FMAX_KHZ;
  localparam int BRF_STEADY_RAW = (BRF_STEADY_NS * BRF_CLK_KHZ + 999999) / 1000000;
  localparam int BRF_STEADY_CYC = (BRF_STEADY_RAW < 1) ? 1 : BRF_STEADY_RAW;
  localparam int BRF_CE_LOW_CYC = 1;
  localparam int BRF_CE_HOLD_CYC = 1;
  localparam int BRF_CNT_W = 8;

endpackage : brf_pkg

// file: hdl/brf_user_drv.sv
// Fabric logic that runs the block memory as a FIFO and sequences its resets.
module brf_user_drv #(
  parameter int DATA_W = brf_pkg::BRF_DATA_W,
  parameter int ADDR_W = brf_pkg::BRF_ADDR_W,
  parameter int HOLD_CYC = brf_pkg::BRF_STEADY_CYC
) (
  input wire logic CLOCK_IN,
  input wire logic RESET_N_IN,
  input wire logic CLK_EN_IN,
  input wire logic PUSH_IN,
  input wire logic [DATA_W-1:0] PUSH_DATA_IN,
  input wire logic POP_IN,
  input wire logic FLUSH_IN,
  input wire logic REWIND_IN,
  output logic READY_OUT,
  output logic FULL_OUT,
  output logic EMPTY_OUT,
  output logic POP_VALID_OUT,
  output logic [DATA_W-1:0] POP_DATA_OUT,
  brf_if.usr MEM_IF
);
  import brf_pkg::*;

  localparam logic [BRF_CNT_W-1:0] HOLD_LAST = BRF_CNT_W'(HOLD_CYC - 1);
  localparam logic [BRF_CNT_W-1:0] QUIET_LAST = BRF_CNT_W'(BRF_CE_LOW_CYC - 1);
  localparam logic [BRF_CNT_W-1:0] SETTLE_LAST = BRF_CNT_W'(BRF_CE_HOLD_CYC - 1);

  brf_seq_e state_reg;
  brf_seq_e state_next;
  logic [BRF_CNT_W-1:0] cnt_reg;
  logic rewind_reg;
  logic boot_reg;
  logic tick_reg;
  logic wr_strobe_reg;
  logic drain_reg;
  logic rst_reg;
  logic rpc_reg;
  logic gsr_reg;
  logic full_in_reg;
  logic empty_in_reg;
  logic [DATA_W-1:0] wr_data_reg;
  logic ack_d_reg;
  logic pop_valid_reg;
  logic [DATA_W-1:0] pop_data_reg;
  logic ready_reg;

  // ------------------------------------------------------------------
  // Sequencer decoding
  // ------------------------------------------------------------------
  // Strobes drop one cycle before any reset and stay off for two cycles after
  // it, so the memory never sees an enabled edge next to a reset edge.
  wire idle = (state_reg == BRF_SEQ_IDLE);
  wire cnt_done_hold = (cnt_reg == HOLD_LAST);
  wire cnt_done_quiet = (cnt_reg == QUIET_LAST);
  wire cnt_done_settle = (cnt_reg == SETTLE_LAST);
  wire start_req = idle & (FLUSH_IN | REWIND_IN);
  wire wr_allow = idle & ~start_req;
  wire rd_allow = idle & ~start_req;
  // Strobes go out only as the port clock is about to rise, so none is lost.
  wire push_ok = wr_allow & PUSH_IN & ~MEM_IF.full_flag & ~tick_reg;
  wire pop_ok = rd_allow & POP_IN & ~MEM_IF.empty_flag & ~drain_reg & ~tick_reg;
  wire hold_on = (state_next == BRF_SEQ_HOLD);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      BRF_SEQ_BOOT: if (cnt_done_hold) state_next = BRF_SEQ_SETTLE;
      BRF_SEQ_IDLE: if (start_req) state_next = BRF_SEQ_QUIET;
      BRF_SEQ_QUIET: if (cnt_done_quiet) state_next = BRF_SEQ_HOLD;
      BRF_SEQ_HOLD: if (cnt_done_hold) state_next = BRF_SEQ_SETTLE;
      BRF_SEQ_SETTLE: if (cnt_done_settle) state_next = BRF_SEQ_IDLE;
      default: state_next = BRF_SEQ_BOOT;
    endcase
  end

  // ------------------------------------------------------------------
  // Sequencer state
  // ------------------------------------------------------------------
  // The global reset is held from power-up and released ahead of the
  // ready indication, so preloaded contents are never reset late.
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_reg <= BRF_SEQ_BOOT;
      cnt_reg <= '0;
      rewind_reg <= 1'b0;
      boot_reg <= 1'b1;
    end else if (CLK_EN_IN) begin
      state_reg <= state_next;
      cnt_reg <= (state_next != state_reg) ? '0 : cnt_reg + 1'b1;
      if (start_req) begin
        rewind_reg <= REWIND_IN & ~FLUSH_IN;
      end
      if (state_reg == BRF_SEQ_SETTLE) begin
        boot_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Drives toward the memory
  // ------------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      tick_reg <= 1'b0;
      wr_strobe_reg <= 1'b0;
      drain_reg <= 1'b0;
      rst_reg <= 1'b0;
      rpc_reg <= 1'b0;
      gsr_reg <= 1'b1;
      full_in_reg <= 1'b0;
      empty_in_reg <= 1'b0;
      wr_data_reg <= '0;
    end else if (CLK_EN_IN) begin
      tick_reg <= ~tick_reg;
      wr_strobe_reg <= push_ok;
      drain_reg <= pop_ok;
      rst_reg <= hold_on & ~rewind_reg & ~boot_reg;
      rpc_reg <= hold_on & rewind_reg & ~boot_reg;
      gsr_reg <= (state_next == BRF_SEQ_BOOT);
      full_in_reg <= MEM_IF.full_flag;
      empty_in_reg <= MEM_IF.empty_flag;
      if (push_ok) begin
        wr_data_reg <= PUSH_DATA_IN;
      end
    end
  end

  // ------------------------------------------------------------------
  // Read return path
  // ------------------------------------------------------------------
  // Data leaves the output register one edge after the acknowledge.
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ack_d_reg <= 1'b0;
      pop_valid_reg <= 1'b0;
      pop_data_reg <= '0;
      ready_reg <= 1'b0;
    end else if (CLK_EN_IN) begin
      ack_d_reg <= MEM_IF.read_ack;
      pop_valid_reg <= ack_d_reg;
      if (ack_d_reg) begin
        pop_data_reg <= MEM_IF.rd_data;
      end
      ready_reg <= (state_next == BRF_SEQ_IDLE);
    end
  end

  // ------------------------------------------------------------------
  // Static and registered drives
  // ------------------------------------------------------------------
  // A half-rate port clock leaves a whole system cycle either side of
  // every port edge, which keeps strobes clear of the edge itself.
  assign MEM_IF.mode = BRF_MODE_FIFO;
  assign MEM_IF.gsr_enable = 1'b1;
  assign MEM_IF.sync_reset_sel = 1'b0;
  assign MEM_IF.global_set_reset = gsr_reg;
  assign MEM_IF.fifo_reset = rst_reg;
  assign MEM_IF.read_pointer_clear = rpc_reg;
  assign MEM_IF.write_port_clock = tick_reg;
  assign MEM_IF.read_port_clock = tick_reg;
  assign MEM_IF.wr_ce = 1'b1;
  assign MEM_IF.rd_ce = 1'b1;
  assign MEM_IF.wr_strobe = wr_strobe_reg;
  assign MEM_IF.drain_strobe = drain_reg;
  assign MEM_IF.write_port_select = BRF_SEL_DRIVE;
  assign MEM_IF.read_port_select = BRF_SEL_DRIVE;
  assign MEM_IF.full_input = full_in_reg;
  assign MEM_IF.empty_input = empty_in_reg;
  assign MEM_IF.output_register_enable = 1'b1;
  assign MEM_IF.output_read_enable = 1'b1;
  assign MEM_IF.byte_lane_enable = '1;
  assign MEM_IF.addr = '0;
  assign MEM_IF.wr_data = wr_data_reg;

  assign READY_OUT = ready_reg;
  assign FULL_OUT = full_in_reg;
  assign EMPTY_OUT = empty_in_reg;
  assign POP_VALID_OUT = pop_valid_reg;
  assign POP_DATA_OUT = pop_data_reg;

endmodule : brf_user_drv

// file: tb/brf_chk_assertions.sv
// Checker for the link between the fabric driver and the block memory.
module brf_chk_assertions (
  input wire logic CLOCK_IN,
  input wire logic RESET_N_IN,
  input var brf_pkg::brf_mode_e mode,
  input wire logic gsr_enable,
  input wire logic fifo_reset,
  input wire logic read_pointer_clear,
  input wire logic wr_strobe,
  input wire logic drain_strobe,
  input wire logic empty_input,
  input wire logic read_ack,
  input wire logic full_flag,
  input wire logic almost_full_flag,
  input wire logic empty_flag,
  input wire logic almost_empty_flag
);
  import brf_pkg::*;
  // ------------------------------------------------------------------
  // Reset ordering and flag relations
  // ------------------------------------------------------------------
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESET_N_IN);
  // Strobes stand in for clock enables, so they must be quiet around resets.
  chk_fifo_gsr_on: assert property (mode == BRF_MODE_FIFO |-> gsr_enable)
    else $error("global reset path off in fifo mode");
  chk_flush_quiet_before: assert property ($rose(fifo_reset) |-> $past(!wr_strobe && !drain_strobe))
    else $error("strobe active before flush");
  chk_flush_strobes_off: assert property (fifo_reset |-> !wr_strobe && !drain_strobe)
    else $error("strobe active during flush");
  chk_flush_settle_quiet: assert property ($fell(fifo_reset) |-> !wr_strobe && !drain_strobe)
    else $error("strobe active right after flush");
  chk_clear_drain_order: assert property ($rose(read_pointer_clear) |-> $past(!drain_strobe))
    else $error("drain active before pointer clear");
  chk_reset_empties_fifo: assert property (fifo_reset |-> empty_flag && almost_empty_flag && !full_flag)
    else $error("flags not cleared by flush");
  chk_empty_implies_ae: assert property (empty_flag |-> almost_empty_flag)
    else $error("empty without almost empty");
  chk_full_implies_af: assert property (full_flag |-> almost_full_flag)
    else $error("full without almost full");
  chk_empty_in_blocks: assert property (empty_input |=> !read_ack)
    else $error("read taken with empty input high");
  chk_ack_needs_drain: assert property (read_ack |-> $past(drain_strobe) ##1 !read_ack)
    else $error("read ack without drain or too long");
  cover property ($rose(fifo_reset));
  cover property ($rose(read_pointer_clear));
  cover property (mode == BRF_MODE_FIFO && empty_flag);
endmodule : brf_chk_assertions

// file: tb/tb_top.sv
// Testbench: driver and memory paired, plus a second memory driven directly.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import brf_pkg::*;
  typedef struct packed {
    logic ce; logic [1:0] sel; logic fi; logic stb; logic [15:0] data; logic taken;
  } brf_row_s;
  localparam int DEPTH = 1 << BRF_ADDR_W;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en_b = 1'b1;
  logic push = 1'b0;
  logic pop = 1'b0;
  logic flush = 1'b0;
  logic rewind = 1'b0;
  logic ready, full_o, empty_o, pop_valid, seen;
  logic [15:0] pop_data;
  int fail_count = 0;
  int cmp_count = 0;
  // Write attempts: only rows with enable, select, strobe all good and full input low land.
  brf_row_s rows [7] = '{'{1, 2'b11, 0, 1, 16'hA1A1, 1}, '{0, 2'b11, 0, 1, 16'h0001, 0},
    '{1, 2'b10, 0, 1, 16'h0002, 0}, '{1, 2'b11, 1, 1, 16'h0003, 0},
    '{1, 2'b11, 0, 0, 16'h0004, 0}, '{1, 2'b01, 0, 1, 16'h0005, 0},
    '{1, 2'b11, 0, 1, 16'hB2B2, 1}};
  brf_if if_a();
  brf_if if_b();
  always #20 clk = ~clk;
  brf_user_drv i_brf_user_drv (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .CLK_EN_IN(1'b1),
    .PUSH_IN(push), .PUSH_DATA_IN(16'h5A5A), .POP_IN(pop), .FLUSH_IN(flush),
    .REWIND_IN(rewind), .READY_OUT(ready), .FULL_OUT(full_o), .EMPTY_OUT(empty_o),
    .POP_VALID_OUT(pop_valid), .POP_DATA_OUT(pop_data), .MEM_IF(if_a.usr));
  brf_mem_dev i_brf_mem_dev (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .CLK_EN_IN(1'b1),
    .MEM_IF(if_a.dev));
  brf_mem_dev i_brf_mem_dev_b (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .CLK_EN_IN(en_b),
    .MEM_IF(if_b.dev));
  brf_chk_assertions i_brf_chk_assertions (.CLOCK_IN(clk), .RESET_N_IN(rst_n),
    .mode(if_a.mode), .gsr_enable(if_a.gsr_enable), .fifo_reset(if_a.fifo_reset),
    .read_pointer_clear(if_a.read_pointer_clear), .wr_strobe(if_a.wr_strobe),
    .drain_strobe(if_a.drain_strobe), .empty_input(if_a.empty_input),
    .read_ack(if_a.read_ack), .full_flag(if_a.full_flag),
    .almost_full_flag(if_a.almost_full_flag), .empty_flag(if_a.empty_flag),
    .almost_empty_flag(if_a.almost_empty_flag));
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic flags(input logic e, input logic ae, input logic af, input logic f);
    chk(if_b.empty_flag, e);
    chk(if_b.almost_empty_flag, ae);
    chk(if_b.almost_full_flag, af);
    chk(if_b.full_flag, f);
  endtask : flags
  // The port acts only on a low-to-high step of its sampled port clock.
  task automatic wr(input brf_row_s r);
    @(posedge clk);
    if_b.wr_ce <= r.ce;
    if_b.write_port_select <= r.sel;
    if_b.full_input <= r.fi;
    if_b.wr_strobe <= r.stb;
    if_b.wr_data <= r.data;
    if_b.write_port_clock <= 1'b1;
    @(posedge clk);
    if_b.write_port_clock <= 1'b0;
    if_b.wr_strobe <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic ack, input logic [15:0] exp);
    @(posedge clk);
    if_b.drain_strobe <= 1'b1;
    if_b.read_port_clock <= 1'b1;
    @(posedge clk);
    if_b.drain_strobe <= 1'b0;
    if_b.read_port_clock <= 1'b0;
    #1 chk(if_b.read_ack, ack);
    @(posedge clk);
    #1 if (ack) chk(if_b.rd_data, exp);
  endtask : rd
  // Flush or rewind through the driver; ready drops, then returns.
  task automatic seq(input logic fl);
    @(posedge clk);
    flush <= fl;
    rewind <= !fl;
    @(posedge clk);
    flush <= 1'b0;
    rewind <= 1'b0;
    #1 chk(ready, 1'b0);
    for (int n = 0; n < 20 && ready !== 1'b1; n++) @(posedge clk);
    #1 chk(ready, 1'b1);
  endtask : seq
  // Async clear with the clock enable low, so only an async path can act.
  task automatic async_pulse(input int which, input logic [3:0] exp);
    @(posedge clk);
    en_b <= 1'b0;
    @(posedge clk);
    if (which == 0) if_b.fifo_reset <= 1'b1;
    if (which == 1) if_b.read_pointer_clear <= 1'b1;
    if (which == 2) if_b.global_set_reset <= 1'b1;
    @(posedge clk);
    #1 if (which != 1) flags(exp[3], exp[2], exp[1], exp[0]);
    @(posedge clk);
    if_b.fifo_reset <= 1'b0;
    if_b.read_pointer_clear <= 1'b0;
    if_b.global_set_reset <= 1'b0;
    @(posedge clk);
    en_b <= 1'b1;
    @(posedge clk);
    #1 flags(exp[3], exp[2], exp[1], exp[0]);
  endtask : async_pulse
  task automatic end_of_test();
    $display("fail_count=%0d cmp_count=%0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    if_b.mode = BRF_MODE_FIFO;
    if_b.gsr_enable = 1'b1;
    if_b.sync_reset_sel = 1'b0;
    if_b.global_set_reset = 1'b0;
    if_b.fifo_reset = 1'b0;
    if_b.read_pointer_clear = 1'b0;
    if_b.write_port_clock = 1'b0;
    if_b.read_port_clock = 1'b0;
    if_b.wr_ce = 1'b0;
    if_b.rd_ce = 1'b1;
    if_b.wr_strobe = 1'b0;
    if_b.drain_strobe = 1'b0;
    if_b.write_port_select = 2'b11;
    if_b.read_port_select = 2'b11;
    if_b.full_input = 1'b0;
    if_b.empty_input = 1'b0;
    if_b.output_register_enable = 1'b1;
    if_b.output_read_enable = 1'b1;
    if_b.byte_lane_enable = '1;
    if_b.addr = '0;
    if_b.wr_data = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int n = 0; n < 20 && ready !== 1'b1; n++) @(posedge clk);
    #1 chk(empty_o, 1'b1);
    chk(full_o, 1'b0);
    @(posedge clk);
    pop <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    seen = 1'b0;
    repeat (6) @(posedge clk) #1 seen |= pop_valid;
    chk(seen, 1'b0);
    // Driver round trip: two pushes, one pop, then a flush.
    push <= 1'b1;
    repeat (4) @(posedge clk);
    push <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk(empty_o, 1'b0);
    pop <= 1'b1;
    repeat (2) @(posedge clk);
    pop <= 1'b0;
    #1 for (int n = 0; n < 8 && pop_valid !== 1'b1; n++) #40;
    chk(pop_valid, 1'b1);
    chk(pop_data, 16'h5A5A);
    seq(1'b1);
    #1 chk(empty_o, 1'b1);
    seq(1'b0);
    foreach (rows[i]) wr(rows[i]);
    foreach (rows[i]) if (rows[i].taken) rd(1'b1, rows[i].data);
    rd(1'b0, 16'h0000);
    for (int i = 1; i <= DEPTH; i++) begin
      wr('{1, 2'b11, 0, 1, 16'h1000 + i[15:0], 1});
      flags(0, i <= BRF_AE_LEVEL, i >= BRF_AF_LEVEL, i == DEPTH);
    end
    wr('{1, 2'b11, 0, 1, 16'hDEAD, 0});
    rd(1'b1, 16'h1001);
    async_pulse(0, 4'b1100);
    for (int i = 1; i <= 3; i++) wr('{1, 2'b11, 0, 1, 16'h2000 + i[15:0], 1});
    rd(1'b1, 16'h2001);
    rd(1'b1, 16'h2002);
    async_pulse(1, 4'b0000);
    rd(1'b1, 16'h2001);
    async_pulse(2, 4'b1100);
    if_b.mode <= BRF_MODE_RAM;
    if_b.addr <= 4'h5;
    wr('{1, 2'b11, 0, 1, 16'hC3C3, 1});
    rd(1'b1, 16'hC3C3);
    if_b.mode <= BRF_MODE_ROM;
    wr('{1, 2'b11, 0, 1, 16'h3C3C, 0});
    rd(1'b1, 16'hC3C3);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1 chk(if_b.rd_data, 16'h0000);
    chk(ready, 1'b0);
    @(posedge clk);
    rst_n <= 1'b1;
    for (int n = 0; n < 20 && ready !== 1'b1; n++) @(posedge clk);
    #1 chk(ready, 1'b1);
    chk(empty_o, 1'b1);
    end_of_test();
  end
  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end
endmodule : tb_top
